// ---- common/slpr_defines.svh ----
// register offsets, reset values, width codes and resolution limits for the link parameter bank
`ifndef SLPR_DEFINES_SVH
`define SLPR_DEFINES_SVH
`define SLPR_IDX_CONV 12'h58e
`define SLPR_IDX_CSN 12'h58f
`define SLPR_IDX_SCNP 12'h590
`define SLPR_IDX_SPF 12'h591
`define SLPR_IDX_DCW 12'h592
`define SLPR_RST_CONV 8'h01
`define SLPR_RST_CS 2'h0
`define SLPR_RST_RES 5'h0f
`define SLPR_RST_SUBCL 3'h1
`define SLPR_RST_NP 5'h0f
`define SLPR_RST_SPF_RSV 3'h1
`define SLPR_RST_SPF 5'h00
`define SLPR_RST_CWPF 5'h00
`define SLPR_NP_8 5'h07
`define SLPR_NP_12 5'h0b
`define SLPR_NP_16 5'h0f
`define SLPR_RES_MIN 5'h06
`define SLPR_RES_MAX 5'h0f
`endif

// ---- common/slpr_pkg.sv ----
// types for the link parameter register bank
package slpr_pkg;
  typedef struct packed {
    logic [7:0] conv;
    logic [1:0] cs;
    logic [4:0] res;
    logic [2:0] subcl;
    logic [4:0] np;
    logic [7:0] dat;
    logic ack;
  } slpr_state_s;
  typedef struct packed {
    logic [3:0] conv_count;
    logic [2:0] ctrl_mask;
    logic [4:0] resolution;
    logic subclass1;
    logic [4:0] sample_bits;
  } slpr_cfg_s;
endpackage

// ---- hw/slpr_regs.sv ----
// wishbone register bank for serial link parameters
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "slpr_defines.svh"
module slpr_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [13:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [4:0] spf_minus1_i,
  input wire logic high_density_flag_i,
  input wire logic [4:0] control_words_per_frame_i,
  output slpr_pkg::slpr_cfg_s cfg_o
);
  import slpr_pkg::*;
  slpr_state_s st_r;
  slpr_state_s st_nxt;
  logic req;
  logic wr;
  logic [11:0] idx;
  logic [7:0] wb;
  assign req = cyc_i & stb_i & ~st_r.ack;
  assign wr = req & we_i & sel_i[0];
  // byte address is four times the printed index
  assign idx = adr_i[13:2];
  assign wb = dat_i[7:0];
  assign dat_o = {24'h000000, st_r.dat};
  assign ack_o = st_r.ack;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = req;
    if (req) begin
      st_nxt.dat = 8'h00;
      if (idx == `SLPR_IDX_CONV) begin
        st_nxt.dat = st_r.conv;
        if (wr) begin
          st_nxt.conv = wb;
        end
      end else if (idx == `SLPR_IDX_CSN) begin
        st_nxt.dat = {st_r.cs, 1'b0, st_r.res};
        if (wr) begin
          st_nxt.cs = wb[7:6];
          st_nxt.res = wb[4:0];
        end
      end else if (idx == `SLPR_IDX_SCNP) begin
        st_nxt.dat = {st_r.subcl, st_r.np};
        if (wr) begin
          st_nxt.subcl = wb[7:5];
          // only three widths supported; others keep the old value
          if (wb[4:0] == `SLPR_NP_8 || wb[4:0] == `SLPR_NP_12 ||
              wb[4:0] == `SLPR_NP_16) begin
            st_nxt.np = wb[4:0];
          end
        end
      end else if (idx == `SLPR_IDX_SPF) begin
        st_nxt.dat = {`SLPR_RST_SPF_RSV, spf_minus1_i};
      end else if (idx == `SLPR_IDX_DCW) begin
        st_nxt.dat = {high_density_flag_i, 2'b00,
                      control_words_per_frame_i};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.conv <= `SLPR_RST_CONV;
      st_r.cs <= `SLPR_RST_CS;
      st_r.res <= `SLPR_RST_RES;
      st_r.subcl <= `SLPR_RST_SUBCL;
      st_r.np <= `SLPR_RST_NP;
      st_r.dat <= 8'h00;
      st_r.ack <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // decoded view for the framer
  always_comb begin
    case (st_r.conv)
      8'h00: cfg_o.conv_count = 4'h1;
      8'h01: cfg_o.conv_count = 4'h2;
      8'h03: cfg_o.conv_count = 4'h4;
      8'h07: cfg_o.conv_count = 4'h8;
      default: cfg_o.conv_count = 4'h0;
    endcase
    case (st_r.cs)
      2'h1: cfg_o.ctrl_mask = 3'h4;
      2'h2: cfg_o.ctrl_mask = 3'h6;
      2'h3: cfg_o.ctrl_mask = 3'h7;
      default: cfg_o.ctrl_mask = 3'h0;
    endcase
    // out-of-range codes report zero resolution
    if (st_r.res >= `SLPR_RES_MIN && st_r.res <= `SLPR_RES_MAX) begin
      cfg_o.resolution = st_r.res + 5'h01;
    end else begin
      cfg_o.resolution = 5'h00;
    end
    cfg_o.subclass1 = (st_r.subcl == 3'h1);
    cfg_o.sample_bits = st_r.np + 5'h01;
  end
endmodule

// ---- sim/slpr_monitor.sv ----
// assertions on the slpr_regs ports
`timescale 1ns/1ps
module slpr_monitor (
  input wire logic clk_i, rst_i, cyc_i, stb_i, ack_o,
  input wire logic [13:0] adr_i,
  input wire logic [31:0] dat_o,
  input slpr_pkg::slpr_cfg_s cfg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  AST_PUL: assert property (ack_o |=> !ack_o) else $error("ack");
  AST_HI: assert property (ack_o |-> dat_o[31:8] == 0)
    else $error("upper");
  AST_RST: assert property ($fell(rst_i) |->
    cfg_o[17:5] == 13'h421) else $error("reset");
  AST_CNV: assert property (cfg_o.conv_count inside {0, 1, 2, 4, 8})
    else $error("count");
  AST_MSK: assert property (cfg_o.ctrl_mask inside {0, 4, 6, 7})
    else $error("mask");
  AST_RES: assert property (cfg_o.resolution inside {0, [7:16]})
    else $error("res");
  // read-only and unmapped words sit above the last writable one
  AST_RO: assert property (ack_o && $past(adr_i) >= 14'h1644
    |=> $stable(cfg_o)) else $error("ro");
endmodule
bind slpr_regs slpr_monitor MON (.*);

// ---- sim/tb.sv ----
// bench with a byte model of the slpr bank
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [13:0] adr_i = 0;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 0, dat_o;
  logic [4:0] spf_minus1_i = 0, control_words_per_frame_i = 0;
  logic high_density_flag_i = 0;
  slpr_pkg::slpr_cfg_s cfg_o;
  int n_errors = 0, n_checks = 0, k, j, m[6] = '{1, 'hf, 'h2f, 0, 0, 0};
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
  always #5 clk_i = ~clk_i;
  slpr_regs DUT (.*);
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wb(logic w, int a, logic [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, 14'(a * 4), 24'h0, d};
    m[3] = {3'h1, spf_minus1_i};
    m[4] = {high_density_flag_i, 2'h0, control_words_per_frame_i};
    for (k = 0; k < 20 && ack_o !== 1; k++) @(posedge clk_i);
    if (k == 20) begin n_errors++; finish_test; end
    {cyc_i, stb_i} <= 0;
    if (!w) `CHK(dat_o, m[a - 'h58e])
    if (w && sel_i[0] && a < 'h590) m[a - 'h58e] = a[0] ? d & 'hdf : d;
    if (w && sel_i[0] && a == 'h590)
      m[2] = {d[7:5], (d[4:0] inside {7, 11, 15} ? d[4:0] : 5'(m[2]))};
  endtask
  initial begin
    void'($urandom(32'hf5d1));
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    for (j = 0; j < 60; j++) begin
      {sel_i, high_density_flag_i, spf_minus1_i, control_words_per_frame_i} <=
        15'($urandom);
      if (j >= 6) wb(1, 'h58e + j % 6, 8'($urandom));
      wb(0, 'h58e + j % 6, 0);
    end
    sel_i <= 4'hf;
    for (j = 0; j < 16; j++) begin
      wb(1, 'h58e, 8'((1 << j % 4) - 1));
      wb(1, 'h58f, 8'(j % 4 << 6 | $urandom % 32));
      wb(1, 'h590, 8'($urandom));
      @(posedge clk_i);
      k = m[1] % 32;
      `CHK(cfg_o.conv_count, 4'(1 << j % 4))
      `CHK(cfg_o.ctrl_mask, 3'(7 << 3 - j % 4))
      `CHK(cfg_o.resolution, k inside {[6:15]} ? k + 1 : 0)
      `CHK(cfg_o.subclass1, m[2] / 32 == 1)
      `CHK(cfg_o.sample_bits, m[2] % 32 + 1)
    end
    // second reset in mid-run must restore every writable field
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    m = '{1, 'hf, 'h2f, 0, 0, 0};
    for (j = 0; j < 6; j++) wb(0, 'h58e + j, 0);
    finish_test;
  end
endmodule
